/* File: tb/rdc_host_model.sv */
// behavioural two-wire bus controller facing the block
`timescale 1ns/100ps
`default_nettype none
module rdc_host_model (
   output logic scl_clk,
   output logic sda_drive,
   input wire logic sda_line
);
   localparam int Q = 100; // quarter bit in ns, well above the sync limit

   // idle bus: clock high, data released to the pull-up
   initial begin
      scl_clk = 1'b1;
      sda_drive = 1'b0;
   end

   // also serves as repeated start from a low clock
   task automatic start_cond();
      sda_drive = 1'b0;
      #Q scl_clk = 1'b1;
      #Q sda_drive = 1'b1;
      #Q scl_clk = 1'b0;
      #Q;
   endtask

   task automatic stop_cond();
      sda_drive = 1'b1;
      #Q scl_clk = 1'b1;
      #Q sda_drive = 1'b0;
      #(2 * Q);
   endtask

   // data changes only while clock low, sampled mid high phase
   task automatic clock_bit(input logic b, output logic r);
      sda_drive = !b;
      #Q scl_clk = 1'b1;
      #Q r = sda_line;
      #Q scl_clk = 1'b0;
      #Q;
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) clock_bit(b[i], r);
      clock_bit(1'b1, r);
      ack = !r;
   endtask

   task automatic recv_byte(output logic [7:0] b, input logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
      clock_bit(nack, r);
   endtask
endmodule
`default_nettype wire

/* File: tb/rdc_i2c_ctrl_monitor.sv */
// pin-level checks of the redriver control block
`timescale 1ns/100ps
`default_nettype none
module rdc_i2c_ctrl_monitor
   import rdc_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic scl_clk,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [2:0] addr_sel,
   input wire rdc_strap_s strap,
   input wire rdc_lane_cfg_s [3:0] lane_cfg,
   input wire logic power_off_bit,
   input wire logic eq_profile_select,
   input wire logic pin_mode_active
);
   logic [3:0] calm_q;
   wire [3:0] eq_sum;
   wire [2:0] eq_exp;
   wire [1:0] rxg_exp;

   // expected strap decode, pins limited to 0..2
   assign eq_sum = {2'h0, strap.eq_level_pin_upper} * 4'h3 + {2'h0, strap.eq_level_pin_lower};
   assign eq_exp = (eq_sum == 4'h0) ? 3'h0 : 3'(eq_sum - 4'h1);
   assign rxg_exp = {strap.rx_gain_pin == 2'h2, strap.rx_gain_pin != 2'h0};

   // cycles since straps last moved; decode is judged only once synchronisers settled
   always_ff @(posedge clock) begin
      if (srst || !$stable(strap)) calm_q <= 4'h0;
      else if (calm_q != 4'hf) calm_q <= calm_q + 4'h1;
   end

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   // the strap sampled now must also be the one the count covers, else the first edge after a change misjudges
   sequence pin_settled;
      pin_mode_active [*3] ##0 (calm_q == 4'hf) ##0 $stable(strap);
   endsequence

   rst_quiet_a: assert property (disable iff (1'b0) srst |=> !sda_oe && !power_off_bit && !pin_mode_active)
      else $error("outputs not cleared by reset");
   open_drain_a: assert property (sda_oe |-> !sda_out)
      else $error("data pin driven high");
   oe_timing_a: assert property ($changed(sda_oe) |-> !$past(scl_clk, 2) && $past(scl_clk, 6))
      else $error("data line changed away from a clock fall");
   ack_hold_a: assert property (sda_oe && scl_clk |=> sda_oe || !scl_clk)
      else $error("data line released during clock high");
   pin_eq_a: assert property (pin_settled |-> lane_cfg[0].eq_strength_code == eq_exp && lane_cfg[3].eq_strength_code == eq_exp)
      else $error("strap strength decode wrong");
   pin_rxg_a: assert property (pin_settled |-> lane_cfg[1].rx_gain == rxg_exp && lane_cfg[2].select_a == (strap.rx_gain_pin == 2'h2))
      else $error("strap gain decode wrong");
   pin_profile_a: assert property (pin_settled |-> eq_profile_select == strap.eq_profile_select)
      else $error("profile not from strap");
   pin_enter_a: assert property ((calm_q == 4'hf) && $stable(strap) && !strap.pin_control_select_n |-> pin_mode_active)
      else $error("select pin low but not in pin mode");
   pin_power_a: assert property ($past(pin_mode_active) && pin_mode_active |-> !power_off_bit)
      else $error("powered down in pin mode");
endmodule
bind rdc_i2c_ctrl rdc_i2c_ctrl_monitor mon_u (.clock(clock), .srst(srst), .scl_clk(scl_clk), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .strap(strap), .lane_cfg(lane_cfg),
   .power_off_bit(power_off_bit), .eq_profile_select(eq_profile_select), .pin_mode_active(pin_mode_active));
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the redriver control block
`timescale 1ns/100ps
`default_nettype none
module testbench
   import rdc_pkg::*;
;
   logic clock;
   logic srst;
   logic [2:0] addr_sel;
   rdc_strap_s strap;
   rdc_lane_cfg_s [3:0] lane_cfg;
   logic sda_out, sda_oe, power_off_bit, eq_profile_select, pin_mode_active, ack;
   logic [3:0] acks;
   logic [7:0] v0, v1;
   wire logic scl_clk;
   wire logic host_drive;
   wire logic sda_line;
   int fails, tests_run, cycles, s;
   logic [7:0] tbl_i [10] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0b, 8'h0c, 8'h0d};
   logic [7:0] tbl_w [10] = '{8'hfa, 8'h9a, 8'hff, 8'h2b, 8'h05, 8'h4c, 8'h06, 8'h7d, 8'h03, 8'hff};
   logic [7:0] tbl_r [10] = '{8'h0a, 8'h9a, 8'h07, 8'h2b, 8'h05, 8'h4c, 8'h06, 8'h7d, 8'h03, 8'h00};
   logic [7:0] ctl [4] = '{8'h9a, 8'h2b, 8'h4c, 8'h7d};
   logic [2:0] stg [4] = '{3'h7, 3'h5, 3'h6, 3'h3};
   logic [7:0] gen_v [4] = '{8'h00, 8'h0c, 8'h3c, 8'h6b};

   // open-drain line with pull-up
   assign sda_line = !(sda_oe || host_drive);

   rdc_i2c_ctrl dut_u (.clock(clock), .srst(srst), .scl_clk(scl_clk), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_sel(addr_sel), .strap(strap), .lane_cfg(lane_cfg), .power_off_bit(power_off_bit),
      .eq_profile_select(eq_profile_select), .pin_mode_active(pin_mode_active));
   rdc_host_model host_u (.scl_clk(scl_clk), .sda_drive(host_drive), .sda_line(sda_line));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // hang guard, about twice the expected run
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 60000) begin
         fails++;
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      logic a0, a1, a2;
      host_u.start_cond();
      host_u.send_byte({4'h0, addr_sel, 1'b0}, a0);
      host_u.send_byte(idx, a1);
      host_u.send_byte(val, a2);
      host_u.stop_cond();
      check({9'h0, a0, a1, a2}, 12'h007, "write acks");
   endtask

   // index write, repeated start, one byte, no acknowledge
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic a0, a1, a2;
      logic [7:0] v;
      host_u.start_cond();
      host_u.send_byte({4'h0, addr_sel, 1'b0}, a0);
      host_u.send_byte(idx, a1);
      host_u.start_cond();
      host_u.send_byte({4'h0, addr_sel, 1'b1}, a2);
      host_u.recv_byte(v, 1'b1);
      host_u.stop_cond();
      check({9'h0, a0, a1, a2}, 12'h007, "read acks");
      check({4'h0, v}, {4'h0, exp}, "read data");
   endtask

   // tracking: bit3 clear follows lane 1, else pair bits
   function automatic rdc_lane_cfg_s lane_exp(input int k, input logic [7:0] gen, input logic [3:0] dis);
      int src;
      src = (!gen[3] || (k == 0 && !gen[5])) ? 1 : (k == 3 && !gen[4]) ? 2 : k;
      return {dis[k], ctl[src][6:0], stg[src]};
   endfunction

   initial begin
      srst = 1'b1;
      addr_sel = 3'h5;
      strap = 8'h80;
      fails = 0;
      tests_run = 0;
      cycles = 0;
      repeat (6) @(negedge clock);
      srst = 1'b0;
      repeat (8) @(negedge clock);
      for (int i = 0; i < 4; i++) check({1'b0, lane_cfg[i]}, 12'h0, "lane reset");
      for (int i = 0; i < 14; i++) rd(8'(i), 8'h00);
      rd(8'h40, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 10; i++) begin
         wr(tbl_i[i], tbl_w[i]);
         rd(tbl_i[i], tbl_r[i]);
      end
      $display("test access kinds done");
      for (int g = 0; g < 4; g++) begin
         wr(8'h00, gen_v[g]);
         rd(8'h00, gen_v[g]);
         for (int k = 0; k < 4; k++) check({1'b0, lane_cfg[k]}, {1'b0, lane_exp(k, gen_v[g], 4'ha)}, "lane");
         check({9'h0, power_off_bit, eq_profile_select, pin_mode_active}, {9'h0, gen_v[g][6], gen_v[g][2], 1'b0}, "gen");
      end
      $display("test tracking done");
      wr(8'h00, 8'hc0);
      check({10'h0, pin_mode_active, power_off_bit}, 12'h2, "pin via register");
      wr(8'h00, 8'h00);
      for (int u = 0; u < 3; u++) for (int l = 0; l < 3; l++) for (int r = 0; r < 3; r++) begin
         strap = {1'b0, l == 1, 2'(u), 2'(l), 2'(r)};
         repeat (20) @(negedge clock);
         s = 3 * u + l;
         check({4'h0, lane_cfg[3].eq_strength_code, lane_cfg[0].rx_gain, lane_cfg[2].select_a, pin_mode_active,
            eq_profile_select}, {4'h0, 3'((s == 0) ? 0 : s - 1), r == 2, r != 0, r == 2, 1'b1, l == 1}, "strap");
      end
      strap = 8'h80;
      repeat (20) @(negedge clock);
      check({11'h0, pin_mode_active}, 12'h0, "register mode back");
      $display("test pin mode done");
      host_u.start_cond();
      host_u.send_byte({4'h0, 3'h4, 1'b0}, ack);
      host_u.stop_cond();
      check({11'h0, ack}, 12'h0, "foreign address");
      @(negedge clock);
      addr_sel = 3'h0;
      repeat (10) @(negedge clock);
      wr(8'h0b, 8'h11);
      rd(8'h0b, 8'h11);
      $display("test addressing done");
      // two data bytes in one frame, then a two-byte read acked in between
      host_u.start_cond();
      host_u.send_byte({4'h0, addr_sel, 1'b0}, acks[3]);
      host_u.send_byte(8'h05, acks[2]);
      host_u.send_byte(8'h3c, acks[1]);
      host_u.send_byte(8'h02, acks[0]);
      host_u.stop_cond();
      check({8'h0, acks}, 12'h00f, "burst write acks");
      check({1'b0, lane_cfg[3]}, {1'b0, 1'b1, 7'h3c, 3'h2}, "burst tracked");
      host_u.start_cond();
      host_u.send_byte({4'h0, addr_sel, 1'b0}, acks[3]);
      host_u.send_byte(8'h05, acks[2]);
      host_u.start_cond();
      host_u.send_byte({4'h0, addr_sel, 1'b1}, acks[1]);
      host_u.recv_byte(v0, 1'b0);
      host_u.recv_byte(v1, 1'b1);
      host_u.stop_cond();
      check({9'h0, acks[3:1]}, 12'h007, "burst read acks");
      check({4'h0, v0}, 12'h03c, "burst first byte");
      check({4'h0, v1}, 12'h002, "burst second byte");
      $display("test burst done");
      summarize();
   end
endmodule
`default_nettype wire

/* File: verilog/rdc_defs.svh */
// index map, field positions and reset values of the redriver control block
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH

// register indices carried in the index byte
`define RDC_IDX_GENERAL 8'h00
`define RDC_IDX_LANE_EN 8'h01
`define RDC_IDX_CTL_BASE 8'h02
`define RDC_IDX_STG_BASE 8'h03
`define RDC_LANE_STRIDE 8'h03

// general settings fields
`define RDC_GEN_PIN_CTRL 7
`define RDC_GEN_PWR_OFF 6
`define RDC_GEN_IND_01 5
`define RDC_GEN_IND_23 4
`define RDC_GEN_IND_ALL 3
`define RDC_GEN_PROFILE 2

// lane control fields
`define RDC_CTL_EQ_MSB 6
`define RDC_CTL_EQ_LSB 4
`define RDC_CTL_TX_GAIN 3
`define RDC_CTL_DC_GAIN 2
`define RDC_CTL_RX_MSB 1
`define RDC_CTL_RX_LSB 0

// stage enable fields
`define RDC_STG_PEAK 2
`define RDC_STG_EQ_DIS 1
`define RDC_STG_DRV_DIS 0

// reset values and bus constants
`define RDC_RST_BYTE 8'h00
`define RDC_RST_NIBBLE 4'h0
`define RDC_RST_STG 3'h0
`define RDC_ADDR_HI 4'h0
`define RDC_LAST_BIT 4'h7
`define RDC_ACK_BIT 4'h8

// three-level strap pin codes
`define RDC_LVL_LOW 2'h0
`define RDC_LVL_FLOAT 2'h1
`define RDC_LVL_HIGH 2'h2
`define RDC_RXG_LOW 2'h0
`define RDC_RXG_FLOAT 2'h1
`define RDC_RXG_HIGH 2'h3

`endif

/* File: verilog/rdc_i2c_ctrl.sv */
// two-wire target, configuration registers and strap decode of the redriver
`timescale 1ns/100ps
`default_nettype none
`include "rdc_defs.svh"
module rdc_i2c_ctrl
   import rdc_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic scl_clk,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [2:0] addr_sel,
   input wire rdc_strap_s strap,
   output rdc_lane_cfg_s [3:0] lane_cfg,
   output logic power_off_bit,
   output logic eq_profile_select,
   output logic pin_mode_active
);

   // index decode for the per-lane register pairs, {hit, lane}
   function automatic logic [2:0] lane_hit(input logic [7:0] idx, input logic [7:0] base);
      logic [2:0] res;
      logic [7:0] at;
      res = 3'h0;
      at = base;
      for (int k = 0; k < 4; k++) begin
         if (idx == at) begin
            res = {1'b1, 2'(k)};
         end
         at = 8'(at + `RDC_LANE_STRIDE);
      end
      return res;
   endfunction

   // strap equalizer decode: 3*upper+lower, minus one, floored
   function automatic logic [2:0] eq_from_pins(input logic [1:0] up, input logic [1:0] lo);
      logic [3:0] sum;
      sum = 4'(({2'h0, up} << 1) + {2'h0, up} + {2'h0, lo});
      return (sum == 4'h0) ? 3'h0 : 3'(sum - 4'h1);
   endfunction

   // pins into the system domain
   logic scl_s;
   logic sda_s;
   logic [2:0] addr_s;
   rdc_strap_s strap_s;

   rdc_sync2 #(.WIDTH(2)) u_sync_bus (
      .clock(clock),
      .srst(srst),
      .d({scl_clk, sda_in}),
      .q({scl_s, sda_s})
   );

   rdc_sync2 #(.WIDTH(3 + $bits(rdc_strap_s))) u_sync_pins (
      .clock(clock),
      .srst(srst),
      .d({addr_sel, strap}),
      .q({addr_s, strap_s})
   );

   // byte assembled on the serial clock itself
   logic [7:0] link_byte;

   rdc_link_shift u_link (
      .scl_clk(scl_clk),
      .sda_in(sda_in),
      .shift_q(link_byte)
   );

   // protocol state
   rdc_state_e state_q, state_d;
   logic scl_p_q;
   logic sda_p_q;
   logic [3:0] bit_cnt_q, bit_cnt_d;
   logic [1:0] byte_cnt_q, byte_cnt_d;
   logic rw_q, rw_d;
   logic ack_q, ack_d;
   logic [7:0] idx_q, idx_d;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic sda_oe_q, sda_oe_d;
   logic wr_en;

   // register file
   logic [7:0] gen_q;
   logic [3:0] len_q;
   logic [7:0] ctl_q [4];
   logic [2:0] stg_q [4];

   // bus events seen through the synchronisers
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire last_rise = scl_rise & (bit_cnt_q == `RDC_LAST_BIT);
   wire byte_done = scl_fall & (bit_cnt_q == `RDC_ACK_BIT);
   wire addr_hit = (link_byte[7:1] == {`RDC_ADDR_HI, addr_s});

   // index decode and read selection
   wire [2:0] ctl_sel = lane_hit(idx_q, `RDC_IDX_CTL_BASE);
   wire [2:0] stg_sel = lane_hit(idx_q, `RDC_IDX_STG_BASE);
   wire wr_gen = wr_en & (idx_q == `RDC_IDX_GENERAL);
   wire wr_len = wr_en & (idx_q == `RDC_IDX_LANE_EN);
   wire wr_ctl = wr_en & ctl_sel[2];
   wire wr_stg = wr_en & stg_sel[2];
   wire [7:0] rd_data = (idx_q == `RDC_IDX_GENERAL) ? gen_q :
                        (idx_q == `RDC_IDX_LANE_EN) ? {4'h0, len_q} :
                        ctl_sel[2] ? ctl_q[ctl_sel[1:0]] :
                        stg_sel[2] ? {5'h00, stg_q[stg_sel[1:0]]} :
                        `RDC_RST_BYTE;
   wire [7:0] idx_inc = 8'(idx_q + 8'h01);

   // next-state logic; a start anywhere restarts framing
   always_comb begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      byte_cnt_d = byte_cnt_q;
      rw_d = rw_q;
      ack_d = ack_q;
      idx_d = idx_q;
      tx_sh_d = tx_sh_q;
      sda_oe_d = sda_oe_q;
      wr_en = 1'b0;
      if (start_ev) begin
         // repeated start behaves the same as the first
         state_d = ST_RX;
         bit_cnt_d = 4'h0;
         byte_cnt_d = 2'h0;
         sda_oe_d = 1'b0;
      end else if (stop_ev) begin
         state_d = ST_IDLE;
         sda_oe_d = 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // nothing happens until the host starts a frame
               sda_oe_d = 1'b0;
            end
            ST_RX: begin
               if (scl_rise) begin
                  bit_cnt_d = 4'(bit_cnt_q + 4'h1);
               end
               if (last_rise) begin
                  ack_d = 1'b1;
                  if (byte_cnt_q == 2'h0) begin
                     ack_d = addr_hit;
                     rw_d = link_byte[0];
                  end else if (byte_cnt_q == 2'h1) begin
                     idx_d = link_byte;
                  end else begin
                     // data byte: store, then step the index
                     wr_en = 1'b1;
                     idx_d = idx_inc;
                  end
               end
               if (byte_done) begin
                  // hold the line low for the whole ninth pulse
                  sda_oe_d = ack_q;
                  state_d = ack_q ? ST_ACK : ST_IDLE;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  sda_oe_d = 1'b0;
                  bit_cnt_d = 4'h0;
                  byte_cnt_d = (byte_cnt_q == 2'h2) ? byte_cnt_q : 2'(byte_cnt_q + 2'h1);
                  state_d = ST_RX;
                  if ((byte_cnt_q == 2'h0) && rw_q) begin
                     // read direction: first bit goes out now
                     state_d = ST_TX;
                     tx_sh_d = rd_data;
                     sda_oe_d = ~rd_data[7];
                     idx_d = idx_inc;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_d = 4'(bit_cnt_q + 4'h1);
               end
               if (byte_done) begin
                  // release so the host can answer
                  sda_oe_d = 1'b0;
                  state_d = ST_TXACK;
               end else if (scl_fall) begin
                  tx_sh_d = {tx_sh_q[6:0], 1'b0};
                  sda_oe_d = ~tx_sh_q[6];
               end
            end
            ST_TXACK: begin
               if (scl_rise) begin
                  // host leaving the line high ends the read
                  ack_d = ~sda_s;
                  state_d = sda_s ? ST_IDLE : ST_TXACK;
               end else if (scl_fall) begin
                  state_d = ST_TX;
                  bit_cnt_d = 4'h0;
                  tx_sh_d = rd_data;
                  sda_oe_d = ~rd_data[7];
                  idx_d = idx_inc;
               end
            end
            default: begin
               state_d = ST_IDLE;
               sda_oe_d = 1'b0;
            end
         endcase
      end
   end

   // protocol registers
   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= ST_IDLE;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         bit_cnt_q <= `RDC_RST_NIBBLE;
         byte_cnt_q <= 2'h0;
         rw_q <= 1'b0;
         ack_q <= 1'b0;
         idx_q <= `RDC_RST_BYTE;
         tx_sh_q <= `RDC_RST_BYTE;
         sda_oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         bit_cnt_q <= bit_cnt_d;
         byte_cnt_q <= byte_cnt_d;
         rw_q <= rw_d;
         ack_q <= ack_d;
         idx_q <= idx_d;
         tx_sh_q <= tx_sh_d;
         sda_oe_q <= sda_oe_d;
      end
   end

   // register writes; unmapped indices fall through untouched
   always_ff @(posedge clock) begin
      if (srst) begin
         gen_q <= `RDC_RST_BYTE;
         len_q <= `RDC_RST_NIBBLE;
         for (int l = 0; l < 4; l++) begin
            ctl_q[l] <= `RDC_RST_BYTE;
            stg_q[l] <= `RDC_RST_STG;
         end
      end else begin
         if (wr_gen) begin
            gen_q <= link_byte;
         end
         if (wr_len) begin
            len_q <= link_byte[3:0];
         end
         if (wr_ctl) begin
            ctl_q[ctl_sel[1:0]] <= link_byte;
         end
         if (wr_stg) begin
            stg_q[stg_sel[1:0]] <= link_byte[2:0];
         end
      end
   end

   // source of configuration: strap pin low or general bit 7
   wire pin_mode = ~strap_s.pin_control_select_n | gen_q[`RDC_GEN_PIN_CTRL];

   // strap-derived lane setting, shared by all lanes
   rdc_lane_cfg_s pin_cfg;
   logic [1:0] pin_rxg;
   assign pin_rxg = (strap_s.rx_gain_pin == `RDC_LVL_LOW) ? `RDC_RXG_LOW :
                    (strap_s.rx_gain_pin == `RDC_LVL_FLOAT) ? `RDC_RXG_FLOAT :
                    `RDC_RXG_HIGH;
   assign pin_cfg = '{
      lane_disable: 1'b0,
      eq_strength_code: eq_from_pins(strap_s.eq_level_pin_upper, strap_s.eq_level_pin_lower),
      tx_gain: 1'b0,
      select_a: (strap_s.rx_gain_pin == `RDC_LVL_HIGH),
      rx_gain: pin_rxg,
      driver_peak_enable: 1'b0,
      eq_stage_disable: 1'b0,
      driver_stage_disable: 1'b0
   };

   // per-lane effective settings with tracking applied
   rdc_lane_cfg_s cfg_d [4];
   always_comb begin
      int src;
      src = 0;
      for (int l = 0; l < 4; l++) begin
         src = l;
         if (!gen_q[`RDC_GEN_IND_ALL]) begin
            src = 1;
         end else if ((l == 0) && !gen_q[`RDC_GEN_IND_01]) begin
            src = 1;
         end else if ((l == 3) && !gen_q[`RDC_GEN_IND_23]) begin
            src = 2;
         end
         cfg_d[l].lane_disable = len_q[l];
         cfg_d[l].eq_strength_code = ctl_q[src][`RDC_CTL_EQ_MSB:`RDC_CTL_EQ_LSB];
         cfg_d[l].tx_gain = ctl_q[src][`RDC_CTL_TX_GAIN];
         cfg_d[l].select_a = ctl_q[src][`RDC_CTL_DC_GAIN];
         cfg_d[l].rx_gain = ctl_q[src][`RDC_CTL_RX_MSB:`RDC_CTL_RX_LSB];
         cfg_d[l].driver_peak_enable = stg_q[src][`RDC_STG_PEAK];
         cfg_d[l].eq_stage_disable = stg_q[src][`RDC_STG_EQ_DIS];
         cfg_d[l].driver_stage_disable = stg_q[src][`RDC_STG_DRV_DIS];
         if (pin_mode) begin
            cfg_d[l] = pin_cfg;
         end
      end
   end

   // outputs straight from flops; power-down only under register control
   always_ff @(posedge clock) begin
      if (srst) begin
         lane_cfg <= '0;
         power_off_bit <= 1'b0;
         eq_profile_select <= 1'b0;
         pin_mode_active <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         for (int l = 0; l < 4; l++) begin
            lane_cfg[l] <= cfg_d[l];
         end
         power_off_bit <= ~pin_mode & gen_q[`RDC_GEN_PWR_OFF];
         eq_profile_select <= pin_mode ? strap_s.eq_profile_select : gen_q[`RDC_GEN_PROFILE];
         pin_mode_active <= pin_mode;
         sda_out <= 1'b0;
         // open drain: only ever pulls low
         sda_oe <= sda_oe_q;
      end
   end

endmodule
`default_nettype wire

/* File: verilog/rdc_link_shift.sv */
// serial-clock side: data bits shift in on each clock rise
`timescale 1ns/100ps
`default_nettype none
module rdc_link_shift (
   input wire logic scl_clk,
   input wire logic sda_in,
   output logic [7:0] shift_q
);

   // no reset: the serial clock stops between frames, and the
   // system side reads this only after counting a full byte
   always_ff @(posedge scl_clk) begin
      shift_q <= {shift_q[6:0], sda_in};
   end

endmodule
`default_nettype wire

/* File: verilog/rdc_pkg.sv */
// types shared by the redriver control block
`default_nettype none
package rdc_pkg;

   // protocol states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX = 5'h02,
      ST_ACK = 5'h04,
      ST_TX = 5'h08,
      ST_TXACK = 5'h10
   } rdc_state_e;

   // effective settings of one lane
   typedef struct packed {
      logic lane_disable;
      logic [2:0] eq_strength_code;
      logic tx_gain;
      logic select_a;
      logic [1:0] rx_gain;
      logic driver_peak_enable;
      logic eq_stage_disable;
      logic driver_stage_disable;
   } rdc_lane_cfg_s;

   // strap pins, three-level pins coded low/float/high = 0/1/2
   typedef struct packed {
      logic pin_control_select_n;
      logic eq_profile_select;
      logic [1:0] eq_level_pin_upper;
      logic [1:0] eq_level_pin_lower;
      logic [1:0] rx_gain_pin;
   } rdc_strap_s;

endpackage
`default_nettype wire

/* File: verilog/rdc_sync2.sv */
// two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/100ps
`default_nettype none
module rdc_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clock) begin
      if (srst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule
`default_nettype wire
